// [common/ops_defines.svh]
// Constants for the output power sequencer: register map, fields, reset values and timing.
//*****************************************************************************
// Overview of operation
// - Control input may act as ignition switch
// - Control input polarity is selectable
// - Startup delay in milliseconds before output on
// - Output turns on only when all conditions good
// - Output voltage setpoint held in millivolts
// - Output stays on for shutdown delay
// - Any shutdown condition starts the shutdown delay
// - Shutdown state reads enabled during timed shutdown
// - Countdown reads remaining milliseconds before off
// - Shutdown cause reported as one code
// - Strap low selects firmware mode, open allows editing while the configuration is unlocked
// - Configuration lock blocks setting changes except unlock, host shutdown and interrupt enables
// - Settings sit in upper 4KB of image
// - Storage area about 4KB, stray files discarded
// - Same command set on both serial ports
// - Abbreviated values decoded per command
//*****************************************************************************
`ifndef OPS_DEFINES_SVH
`define OPS_DEFINES_SVH

//*****************************************************************************
// APB register byte offsets.
//*****************************************************************************
`define OPS_ADDR_CTRL       12'h000
`define OPS_ADDR_START_DLY  12'h004
`define OPS_ADDR_STOP_DLY   12'h008
`define OPS_ADDR_SETPOINT   12'h00c
`define OPS_ADDR_STATE      12'h010
`define OPS_ADDR_COUNT      12'h014
`define OPS_ADDR_CAUSE      12'h018
`define OPS_ADDR_IRQ_STAT   12'h01c
`define OPS_ADDR_IRQ_EN     12'h020
`define OPS_ADDR_IRQ_CLR    12'h024
`define OPS_ADDR_CFG_INFO   12'h028

//*****************************************************************************
// Control register fields.
//*****************************************************************************
`define OPS_CTRL_IGN_BIT    0
`define OPS_CTRL_POL_BIT    1
`define OPS_CTRL_LOCK_BIT   2
`define OPS_CTRL_HOST_BIT   3

//*****************************************************************************
// Reset values.
//*****************************************************************************
`define OPS_START_DLY_RST   32'h000003e8
`define OPS_STOP_DLY_RST    32'h00002710
`define OPS_SETPOINT_RST    32'h00002f2b
`define OPS_IRQ_EN_RST      4'h0
// Pin stages after reset: strap open, every condition bad, control low.
`define OPS_SYNC_RST        5'h10

//*****************************************************************************
// Settings storage window: 4KB at top of a 64KB image.
//*****************************************************************************
`define OPS_CFG_BASE        32'h0000f000
`define OPS_CFG_SIZE        32'h00001000

//*****************************************************************************
// Timing: 40 MHz clock, 1 ms tick.
//*****************************************************************************
`define OPS_CLK_HZ          40000000
`define OPS_TICK_US         1000
`define OPS_TICK_CYC        ((`OPS_CLK_HZ / 1000000) * `OPS_TICK_US)

//*****************************************************************************
// Interrupt bits.
//*****************************************************************************
`define OPS_IRQ_ON          0
`define OPS_IRQ_SDSTART     1
`define OPS_IRQ_OFF         2
`define OPS_IRQ_ABORT       3

`endif

// [common/ops_pkg.sv]
// Types shared by the output power sequencer.
package ops_pkg;

	// Sequencer states, Gray coded along off, startup, on, shutdown.
	typedef enum logic [1:0] {
		OPS_OFF      = 2'b00,
		OPS_STARTUP  = 2'b01,
		OPS_ON       = 2'b11,
		OPS_SHUTDOWN = 2'b10
	} ops_state_t;

	// Shutdown cause codes.
	typedef enum logic [2:0] {
		OPS_CAUSE_NONE = 3'h0,
		OPS_CAUSE_SD   = 3'h1,
		OPS_CAUSE_MV   = 3'h2,
		OPS_CAUSE_BV   = 3'h3,
		OPS_CAUSE_TP   = 3'h4,
		OPS_CAUSE_HC   = 3'h5
	} ops_cause_t;

endpackage

// [core/ops_sequencer.sv]
// Output power sequencer with APB register access and interrupt.
`timescale 1ns/10ps
`include "ops_defines.svh"

module ops_sequencer (
	input  wire logic        CLK,           // System clock, 40 MHz.
	input  wire logic        RST,           // Asynchronous active-high reset.
	input  wire logic        PSEL,          // APB select.
	input  wire logic        PENABLE,       // APB access phase.
	input  wire logic        PWRITE,        // APB direction.
	input  wire logic [11:0] PADDR,         // APB byte address.
	input  wire logic [31:0] PWDATA,        // APB write data.
	output logic      [31:0] PRDATA,        // APB read data.
	output logic             PREADY,        // APB ready.
	output logic             PSLVERR,       // APB error.
	input  wire logic        CTRL_IN,       // Control input pin.
	input  wire logic        VIN_OK,        // Input voltage in range.
	input  wire logic        TEMP_OK,       // Temperature in range.
	input  wire logic        BANK_OK,       // Capacitor bank at or above minimum threshold.
	input  wire logic        STRAP_N,       // Firmware strap pin, low when grounded.
	output logic             OUT_EN,        // Main output enable.
	output logic             FW_MODE,       // USB in firmware replacement mode.
	output logic             CFG_EDIT,      // Settings file editing allowed.
	output logic             IRQ            // Level interrupt.
);

	//*****************************************************************************
	// Input synchronisers.
	//*****************************************************************************
	logic [4:0] sync1_r;   // First stage, read only by the second stage.
	logic [4:0] sync2_r;   // Second stage, safe for logic.

	// Two flip-flops for every pin input.
	// Reset leaves the conditions bad and the strap open, so that no startup
	// can begin before the real pin levels have come through both stages.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1_r <= `OPS_SYNC_RST;
			sync2_r <= `OPS_SYNC_RST;
		end else begin
			sync1_r <= {STRAP_N, BANK_OK, TEMP_OK, VIN_OK, CTRL_IN};
			sync2_r <= sync1_r;
		end
	end

	logic ctrl_s;          // Synchronised control input.
	logic vin_s;           // Synchronised voltage status.
	logic temp_s;          // Synchronised temperature status.
	logic bank_s;          // Synchronised bank status.
	logic strap_n_s;       // Synchronised strap.
	assign ctrl_s    = sync2_r[0];
	assign vin_s     = sync2_r[1];
	assign temp_s    = sync2_r[2];
	assign bank_s    = sync2_r[3];
	assign strap_n_s = sync2_r[4];

	//*****************************************************************************
	// Settings registers.
	//*****************************************************************************
	logic        ign_mode_r;     // Control input acts as ignition switch.
	logic        ctrl_pol_r;     // Control input active high when set.
	logic        lock_r;         // Configuration lock.
	logic        host_sd_r;      // Host-requested shutdown.
	logic [31:0] startup_delay_ms_r;    // Startup delay.
	logic [31:0] shutdown_delay_ms_r;   // Shutdown delay.
	logic [31:0] output_voltage_setpoint_r;  // Output setpoint in mV.
	logic [3:0]  irq_en_r;       // Interrupt enables.

	logic wr_en;           // APB write taken this cycle.
	logic rd_en;           // APB read taken this cycle.
	assign wr_en = PSEL & PENABLE & PWRITE;
	assign rd_en = PSEL & PENABLE & ~PWRITE;

	// Decodes a known offset; used by the error path only.
	function automatic logic addr_known(input logic [11:0] a);
		case (a)
			`OPS_ADDR_CTRL, `OPS_ADDR_START_DLY, `OPS_ADDR_STOP_DLY, `OPS_ADDR_SETPOINT,
			`OPS_ADDR_STATE, `OPS_ADDR_COUNT, `OPS_ADDR_CAUSE, `OPS_ADDR_IRQ_STAT,
			`OPS_ADDR_IRQ_EN, `OPS_ADDR_IRQ_CLR, `OPS_ADDR_CFG_INFO: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction

	// Settings writes; the lock freezes everything except unlock, host shutdown and interrupt enables.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ign_mode_r                <= 1'b0;
			ctrl_pol_r                <= 1'b0;
			lock_r                    <= 1'b0;
			host_sd_r                 <= 1'b0;
			startup_delay_ms_r        <= `OPS_START_DLY_RST;
			shutdown_delay_ms_r       <= `OPS_STOP_DLY_RST;
			output_voltage_setpoint_r <= `OPS_SETPOINT_RST;
			irq_en_r                  <= `OPS_IRQ_EN_RST;
		end else if (wr_en) begin
			case (PADDR)
				`OPS_ADDR_CTRL: begin
					// Each bit holds one short setting, read by the meaning of its own field.
					lock_r    <= PWDATA[`OPS_CTRL_LOCK_BIT];
					host_sd_r <= PWDATA[`OPS_CTRL_HOST_BIT];
					if (!lock_r) begin
						ign_mode_r <= PWDATA[`OPS_CTRL_IGN_BIT];
						ctrl_pol_r <= PWDATA[`OPS_CTRL_POL_BIT];
					end
				end
				`OPS_ADDR_START_DLY: if (!lock_r) startup_delay_ms_r <= PWDATA;
				`OPS_ADDR_STOP_DLY:  if (!lock_r) shutdown_delay_ms_r <= PWDATA;
				`OPS_ADDR_SETPOINT:  if (!lock_r) output_voltage_setpoint_r <= PWDATA;
				`OPS_ADDR_IRQ_EN: irq_en_r <= PWDATA[3:0];
				default: ;
			endcase
		end
	end

	//*****************************************************************************
	// Shutdown conditions and cause.
	//*****************************************************************************
	logic ctrl_active;     // Control input at its active level.
	logic ctrl_bad;        // Ignition off, when used as ignition.
	logic any_bad;         // Any shutdown condition present.
	ops_pkg::ops_cause_t cause_now;  // Highest-priority present cause.

	assign ctrl_active = ctrl_pol_r ? ctrl_s : ~ctrl_s;
	assign ctrl_bad    = ign_mode_r & ~ctrl_active;
	assign any_bad     = ~vin_s | ~temp_s | ~bank_s | ctrl_bad | host_sd_r;

	// Fixed priority picks a single cause.
	always_comb begin
		if (ctrl_bad)      cause_now = ops_pkg::OPS_CAUSE_SD;
		else if (!vin_s)   cause_now = ops_pkg::OPS_CAUSE_MV;
		else if (!bank_s)  cause_now = ops_pkg::OPS_CAUSE_BV;
		else if (!temp_s)  cause_now = ops_pkg::OPS_CAUSE_TP;
		else if (host_sd_r) cause_now = ops_pkg::OPS_CAUSE_HC;
		else               cause_now = ops_pkg::OPS_CAUSE_NONE;
	end

	//*****************************************************************************
	// Millisecond tick.
	//*****************************************************************************
	logic [15:0] div_r;    // Tick divider.
	logic        tick_r;   // One-cycle pulse per millisecond.

	// Counts up the cycles of one millisecond.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else if (div_r == 16'(`OPS_TICK_CYC - 1)) begin
			div_r  <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	//*****************************************************************************
	// Sequencer state machine.
	//*****************************************************************************
	ops_pkg::ops_state_t state_r;    // Current state.
	logic [31:0]         count_r;    // Remaining milliseconds.
	ops_pkg::ops_cause_t cause_r;    // Latched shutdown cause.
	logic [3:0]          ev_set;     // Event pulses this cycle.

	// Startup waits for good conditions, shutdown keeps output on for the delay.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_r <= ops_pkg::OPS_OFF;
			count_r <= 32'h00000000;
			cause_r <= ops_pkg::OPS_CAUSE_NONE;
		end else begin
			case (state_r)
				ops_pkg::OPS_OFF: begin
					cause_r <= ops_pkg::OPS_CAUSE_NONE;
					if (!any_bad) begin
						state_r <= ops_pkg::OPS_STARTUP;
						count_r <= startup_delay_ms_r;
					end
				end
				ops_pkg::OPS_STARTUP: begin
					if (any_bad) begin
						state_r <= ops_pkg::OPS_OFF;
						count_r <= 32'h00000000;
					end else if (count_r == 32'h00000000) begin
						state_r <= ops_pkg::OPS_ON;
					end else if (tick_r) begin
						count_r <= count_r - 32'h00000001;
					end
				end
				ops_pkg::OPS_ON: begin
					if (any_bad) begin
						state_r <= ops_pkg::OPS_SHUTDOWN;
						count_r <= shutdown_delay_ms_r;
						cause_r <= cause_now;
					end
				end
				ops_pkg::OPS_SHUTDOWN: begin
					if (count_r == 32'h00000000) begin
						state_r <= ops_pkg::OPS_OFF;
						cause_r <= ops_pkg::OPS_CAUSE_NONE;
					end else if (tick_r) begin
						count_r <= count_r - 32'h00000001;
					end
				end
				default: state_r <= ops_pkg::OPS_OFF;
			endcase
		end
	end

	// Events that feed the sticky status.
	always_comb begin
		ev_set = 4'h0;
		ev_set[`OPS_IRQ_ON]      = (state_r == ops_pkg::OPS_STARTUP) & ~any_bad & (count_r == 32'h00000000);
		ev_set[`OPS_IRQ_SDSTART] = (state_r == ops_pkg::OPS_ON) & any_bad;
		ev_set[`OPS_IRQ_OFF]     = (state_r == ops_pkg::OPS_SHUTDOWN) & (count_r == 32'h00000000);
		ev_set[`OPS_IRQ_ABORT]   = (state_r == ops_pkg::OPS_STARTUP) & any_bad;
	end

	//*****************************************************************************
	// Interrupt status, clear and output.
	//*****************************************************************************
	logic [3:0] irq_stat_r;   // Sticky event bits.
	logic [3:0] irq_clr;      // Write-one-to-clear mask.
	assign irq_clr = (wr_en && PADDR == `OPS_ADDR_IRQ_CLR) ? PWDATA[3:0] : 4'h0;

	// Set wins over clear in the same cycle.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) irq_stat_r <= 4'h0;
		else     irq_stat_r <= (irq_stat_r & ~irq_clr) | ev_set;
	end

	// Registered interrupt level.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) IRQ <= 1'b0;
		else     IRQ <= |(irq_stat_r & irq_en_r);
	end

	//*****************************************************************************
	// Outputs.
	//*****************************************************************************
	// Output on through startup-complete and the timed shutdown; strap decides mode.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			OUT_EN   <= 1'b0;
			FW_MODE  <= 1'b0;
			CFG_EDIT <= 1'b0;
		end else begin
			OUT_EN   <= (state_r == ops_pkg::OPS_ON) | (state_r == ops_pkg::OPS_SHUTDOWN);
			FW_MODE  <= ~strap_n_s;
			CFG_EDIT <= strap_n_s & ~lock_r;
		end
	end

	//*****************************************************************************
	// APB read path, zero wait states.
	//*****************************************************************************
	logic [31:0] rd_mux;   // Selected read value.

	// Read mux; the setting values apply alike to every command port.
	always_comb begin
		case (PADDR)
			`OPS_ADDR_CTRL:     rd_mux = {28'h0000000, host_sd_r, lock_r, ctrl_pol_r, ign_mode_r};
			`OPS_ADDR_START_DLY: rd_mux = startup_delay_ms_r;
			`OPS_ADDR_STOP_DLY: rd_mux = shutdown_delay_ms_r;
			`OPS_ADDR_SETPOINT: rd_mux = output_voltage_setpoint_r;
			`OPS_ADDR_STATE:    rd_mux = {30'h00000000, state_r == ops_pkg::OPS_STARTUP,
				state_r == ops_pkg::OPS_SHUTDOWN};
			`OPS_ADDR_COUNT:    rd_mux = (state_r == ops_pkg::OPS_SHUTDOWN) ? count_r : 32'h00000000;
			`OPS_ADDR_CAUSE:    rd_mux = {29'h00000000, cause_r};
			`OPS_ADDR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_r};
			`OPS_ADDR_IRQ_EN:   rd_mux = {28'h0000000, irq_en_r};
			`OPS_ADDR_CFG_INFO: rd_mux = `OPS_CFG_BASE | `OPS_CFG_SIZE;
			default:            rd_mux = 32'h00000000;
		endcase
	end

	// Registered answer in the access phase.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PRDATA  <= 32'h00000000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~addr_known(PADDR);
			PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : 32'h00000000;
		end
	end

	//*****************************************************************************
	// Assertions.
	//*****************************************************************************
	property p_startup_abort;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_STARTUP && any_bad) |=> (state_r == ops_pkg::OPS_OFF) ##1 !OUT_EN;
	endproperty
	a_startup_abort: assert property (p_startup_abort) else $error("startup not abandoned");

	property p_on_needs_good;
		@(posedge CLK) disable iff (RST)
		$rose(state_r == ops_pkg::OPS_ON)
			|-> $past(vin_s) && $past(temp_s) && $past(bank_s);
	endproperty
	a_on_needs_good: assert property (p_on_needs_good) else $error("output on with bad conditions");

	property p_sd_start;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_ON && any_bad)
			|=> state_r == ops_pkg::OPS_SHUTDOWN && count_r == $past(shutdown_delay_ms_r);
	endproperty
	a_sd_start: assert property (p_sd_start) else $error("shutdown delay not started");

	property p_out_in_sd;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_SHUTDOWN) |=> OUT_EN;
	endproperty
	a_out_in_sd: assert property (p_out_in_sd) else $error("output off during shutdown");

	property p_tick_dec;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_SHUTDOWN && tick_r && count_r != 32'h00000000)
			|=> count_r == $past(count_r) - 32'h00000001;
	endproperty
	a_tick_dec: assert property (p_tick_dec) else $error("countdown not decremented");

	property p_lock;
		@(posedge CLK) disable iff (RST)
		(lock_r && wr_en) |=> $stable(startup_delay_ms_r) && $stable(shutdown_delay_ms_r);
	endproperty
	a_lock: assert property (p_lock) else $error("setting changed while locked");

	property p_cause;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_SHUTDOWN) |-> cause_r != ops_pkg::OPS_CAUSE_NONE;
	endproperty
	a_cause: assert property (p_cause) else $error("no cause during shutdown");

	property p_strap;
		@(posedge CLK) disable iff (RST)
		!STRAP_N [*3] |=> FW_MODE && !CFG_EDIT;
	endproperty
	a_strap: assert property (p_strap) else $error("strap not honoured");

	property p_pol;
		@(posedge CLK) disable iff (RST)
		(ign_mode_r && state_r == ops_pkg::OPS_ON && (ctrl_s != ctrl_pol_r)) |=> state_r == ops_pkg::OPS_SHUTDOWN;
	endproperty
	a_pol: assert property (p_pol) else $error("ignition off ignored");

	// The output stays off until the startup countdown has run out.
	property p_held_off;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_OFF || state_r == ops_pkg::OPS_STARTUP) |=> !OUT_EN;
	endproperty
	a_held_off: assert property (p_held_off) else $error("output on before startup delay ran out");

	// Outside a timed shutdown the cause reads as none.
	property p_cause_idle;
		@(posedge CLK) disable iff (RST)
		(state_r != ops_pkg::OPS_SHUTDOWN) |-> cause_r == ops_pkg::OPS_CAUSE_NONE;
	endproperty
	a_cause_idle: assert property (p_cause_idle) else $error("cause shown with no shutdown in progress");

	// An abandoned startup leaves its sticky flag behind.
	property p_abort_flag;
		@(posedge CLK) disable iff (RST)
		(state_r == ops_pkg::OPS_STARTUP && any_bad) |=> irq_stat_r[`OPS_IRQ_ABORT];
	endproperty
	a_abort_flag: assert property (p_abort_flag) else $error("startup abort not flagged");

	// The lock also freezes the setpoint and the control-input settings.
	property p_lock_setting;
		@(posedge CLK) disable iff (RST)
		(lock_r && wr_en) |=> $stable(output_voltage_setpoint_r) && $stable(ign_mode_r) && $stable(ctrl_pol_r);
	endproperty
	a_lock_setting: assert property (p_lock_setting) else $error("locked setting changed");

	// Every read access phase carries its answer.
	property p_read_ready;
		@(posedge CLK) disable iff (RST)
		rd_en |-> PREADY;
	endproperty
	a_read_ready: assert property (p_read_ready) else $error("read access left unanswered");

endmodule // ops_sequencer

// [tb/ops_env_model.sv]
// Environment model that drives the sequencer's condition, control and strap pins.
`timescale 1ns/10ps

module ops_env_model (
	input  wire logic CLK,     // Bench clock; pins change only just after its rising edge.
	output logic      CTRL_IN, // Control pin level, ignition style.
	output logic      VIN_OK,  // Input voltage in range.
	output logic      TEMP_OK, // Temperature in range.
	output logic      BANK_OK, // Capacitor bank at or above its minimum threshold.
	output logic      STRAP_N  // Firmware strap; pulled high when left open.
);
	// Every condition starts bad and the strap starts open.
	initial begin
		{CTRL_IN, VIN_OK, TEMP_OK, BANK_OK, STRAP_N} = 5'h01;
	end

	// Applies {control, voltage, temperature, bank, strap}; callers sit just after a rising edge of CLK.
	// An open strap shows the pull-up level, never a stale value.
	task drive(input logic [4:0] pins);
		CTRL_IN <= pins[4];
		VIN_OK  <= pins[3];
		TEMP_OK <= pins[2];
		BANK_OK <= pins[1];
		STRAP_N <= pins[0];
	endtask
endmodule // ops_env_model

// [tb/output_power_sequencer_tb_top.sv]
// Self-checking testbench for the output power sequencer.
`timescale 1ns/10ps
`include "ops_defines.svh"

module output_power_sequencer_tb_top;
	//*****************************************************************************
	// Signals and scenario tables.
	//*****************************************************************************
	logic        CLK;                       // 40 MHz bench clock.
	logic        RST;                       // Active-high reset.
	logic        PSEL, PENABLE, PWRITE;     // APB request.
	logic [11:0] PADDR;                     // APB byte address.
	logic [31:0] PWDATA, PRDATA, rd;        // APB data and last read word.
	logic        PREADY, PSLVERR, er;       // APB answer and last error flag.
	logic        CTRL_IN, VIN_OK, TEMP_OK, BANK_OK, STRAP_N, OUT_EN, FW_MODE, CFG_EDIT, IRQ;
	int          error_cnt, checks_done;    // Mismatch and comparison counters.
	logic [4:0]  good_t [6] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h0f}; // Pins that allow the output.
	logic [4:0]  bad_t  [6] = '{5'h0f, 5'h17, 5'h1d, 5'h1b, 5'h1f, 5'h1f}; // Pins at shutdown; the host case keeps them all good.
	logic [3:0]  pre_t  [6] = '{4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1};       // Control word before turn-on.
	logic [3:0]  post_t [6] = '{4'h3, 4'h0, 4'h0, 4'h0, 4'h8, 4'h1};       // Control word at shutdown.
	logic [2:0]  cause_t[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};       // Expected cause code.

	ops_sequencer DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CTRL_IN(CTRL_IN), .VIN_OK(VIN_OK),
		.TEMP_OK(TEMP_OK), .BANK_OK(BANK_OK), .STRAP_N(STRAP_N), .OUT_EN(OUT_EN), .FW_MODE(FW_MODE),
		.CFG_EDIT(CFG_EDIT), .IRQ(IRQ));
	ops_env_model env (.CLK(CLK), .CTRL_IN(CTRL_IN), .VIN_OK(VIN_OK), .TEMP_OK(TEMP_OK), .BANK_OK(BANK_OK),
		.STRAP_N(STRAP_N));

	// Free-running clock, 25 ns period.
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	//*****************************************************************************
	// Bench tasks.
	//*****************************************************************************
	// Compares a seen value with the expected one and reports any difference.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request holds until PREADY is seen at a rising edge, then an idle edge follows.
	// Only the watchdog ends a wait for ready.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask

	// Reads a register and compares it with the expected word.
	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// Waits a bounded number of cycles for the output enable to reach a level.
	task wait_out(input logic v, input int lim);
		int n;
		n = 0;
		while (OUT_EN !== v && n < lim) begin
			@(posedge CLK);
			n++;
		end
		check({31'h0, OUT_EN}, {31'h0, v});
	endtask

	// Holds reset for four cycles.
	task do_reset;
		RST <= 1'b1;
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task print_verdict;
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Cuts a hang short; the longest scenario waits out one 40000-cycle tick.
	initial begin
		repeat (60000) @(posedge CLK);
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict;
	end

	//*****************************************************************************
	// Main sequence.
	//*****************************************************************************
	initial begin
		{RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 47'h0};
		error_cnt = 0;
		checks_done = 0;
		do_reset;
		// Reset values, settings window and an unmapped address.
		rdchk(`OPS_ADDR_START_DLY, `OPS_START_DLY_RST);
		rdchk(`OPS_ADDR_STOP_DLY, `OPS_STOP_DLY_RST);
		rdchk(`OPS_ADDR_SETPOINT, `OPS_SETPOINT_RST);
		rdchk(`OPS_ADDR_IRQ_EN, 32'h0);
		rdchk(`OPS_ADDR_CFG_INFO, `OPS_CFG_BASE | `OPS_CFG_SIZE);
		rdchk(12'h030, 32'h0);
		check({31'h0, er}, 32'h1);
		// Grounded strap selects firmware mode; open strap allows editing.
		env.drive(5'h00);
		repeat (5) @(posedge CLK);
		check({30'h0, FW_MODE, CFG_EDIT}, 32'h2);
		env.drive(5'h01);
		repeat (5) @(posedge CLK);
		check({30'h0, FW_MODE, CFG_EDIT}, 32'h1);
		// Lock blocks a setpoint change and editing.
		apb(1'b1, `OPS_ADDR_SETPOINT, 32'h0000141e);
		apb(1'b1, `OPS_ADDR_CTRL, 32'h4);
		apb(1'b1, `OPS_ADDR_SETPOINT, 32'h1);
		rdchk(`OPS_ADDR_SETPOINT, 32'h0000141e);
		rdchk(`OPS_ADDR_CTRL, 32'h4);
		check({31'h0, CFG_EDIT}, 32'h0);
		// A bad condition during a startup countdown abandons it.
		apb(1'b1, `OPS_ADDR_CTRL, 32'h0);
		apb(1'b1, `OPS_ADDR_START_DLY, 32'h1);
		env.drive(5'h1f);
		repeat (6) @(posedge CLK);
		rdchk(`OPS_ADDR_STATE, 32'h2);
		env.drive(5'h1b);
		repeat (6) @(posedge CLK);
		rdchk(`OPS_ADDR_STATE, 32'h0);
		apb(1'b0, `OPS_ADDR_IRQ_STAT, 32'h0);
		check({31'h0, rd[3]}, 32'h1);
		check({31'h0, OUT_EN}, 32'h0);
		// Each shutdown cause, with a fresh reset per case.
		for (int k = 0; k < 6; k++) begin
			// Voltage is made bad before reset so that no startup slips in meanwhile.
			env.drive(good_t[k] & 5'h17);
			do_reset;
			apb(1'b1, `OPS_ADDR_START_DLY, 32'h0);
			apb(1'b1, `OPS_ADDR_STOP_DLY, 32'h1);
			apb(1'b1, `OPS_ADDR_CTRL, {28'h0, pre_t[k]});
			apb(1'b1, `OPS_ADDR_IRQ_EN, 32'h7);
			check({31'h0, OUT_EN}, 32'h0);
			env.drive(good_t[k]);
			wait_out(1'b1, 40);
			check({31'h0, IRQ}, 32'h1);
			apb(1'b1, `OPS_ADDR_IRQ_CLR, 32'h1);
			// The interrupt level trails the cleared status by one register stage.
			@(posedge CLK);
			check({31'h0, IRQ}, 32'h0);
			apb(1'b1, `OPS_ADDR_CTRL, {28'h0, post_t[k]});
			env.drive(bad_t[k]);
			repeat (6) @(posedge CLK);
			rdchk(`OPS_ADDR_STATE, 32'h1);
			rdchk(`OPS_ADDR_COUNT, 32'h1);
			rdchk(`OPS_ADDR_CAUSE, {29'h0, cause_t[k]});
			check({31'h0, OUT_EN}, 32'h1);
			if (k == 1) begin
				wait_out(1'b0, 45000);
				rdchk(`OPS_ADDR_STATE, 32'h0);
				rdchk(`OPS_ADDR_CAUSE, 32'h0);
				rdchk(`OPS_ADDR_IRQ_STAT, 32'h6);
				check({31'h0, IRQ}, 32'h1);
			end
		end
		print_verdict;
	end
endmodule // output_power_sequencer_tb_top
